// >>> shared/dbec_pkg.sv
package dbec_pkg;

    // Coprocessor scan chain layout
    localparam int          SC_LEN        = 39;
    localparam int          SC_RW_BIT     = 38;
    localparam int          SC_ADDR_HI    = 37;
    localparam int          SC_ADDR_LO    = 32;
    localparam logic [5:0]  SC_CACHE_INDEX = 6'h3a;
    localparam logic [3:0]  SC_ARRAY_GROUP = 4'h5;

    // Array select, low two address bits of the array group
    localparam logic [1:0]  ARR_DDATA     = 2'h0;
    localparam logic [1:0]  ARR_IDATA     = 2'h1;
    localparam logic [1:0]  ARR_DTAG      = 2'h2;
    localparam logic [1:0]  ARR_ITAG      = 2'h3;

    // Cache index register fields, index top bit fixed at 9
    localparam int          IDX_SEG_HI    = 31;
    localparam int          IDX_SEG_LO    = 30;
    localparam int          IDX_N         = 9;
    localparam int          IDX_LO        = 5;
    localparam int          IDX_WORD_HI   = 4;
    localparam int          IDX_WORD_LO   = 2;
    localparam logic [31:0] IDX_MASK      = 32'hc000_03fc;
    localparam logic [31:0] IDX_RESET     = 32'h0000_0000;

    // Cache RAM: array(2) segment(2) index(5) word(3)
    localparam int          RAM_AW        = 12;
    localparam int          RAM_DW        = 32;

    // Watchpoint entry leaves the PC this many bytes ahead
    localparam logic [31:0] WATCH_PC_SKEW = 32'h0000_0014;

    typedef enum logic [4:0] {
        ST_RUN    = 5'h01,
        ST_WATCH  = 5'h02,
        ST_WDELAY = 5'h04,
        ST_EXCSEQ = 5'h08,
        ST_HALT   = 5'h10
    } dbec_state_t;

endpackage

// >>> verilog/dbec_cache_ram.sv
`timescale 1ns/10ps
module dbec_cache_ram
    import dbec_pkg::*;
(
    // Clock
    input  wire logic              clk_in,
    // Access
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    input  wire logic [RAM_AW-1:0] addr_in,
    input  wire logic [RAM_DW-1:0] wdata_in,
    output logic      [RAM_DW-1:0] rdata_out
);

    logic [RAM_DW-1:0] mem_reg [0:(1<<RAM_AW)-1];

    // No reset: contents are whatever the arrays hold
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_reg[addr_in] <= wdata_in;
        end
        if (rd_en_in) begin
            rdata_out <= mem_reg[addr_in];
        end
    end

endmodule

// >>> verilog/dbec_scan15.sv
`timescale 1ns/10ps
module dbec_scan15
    import dbec_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Test port state strobes
    input  wire logic        select_in,
    input  wire logic        capture_in,
    input  wire logic        shift_in,
    input  wire logic        update_in,
    input  wire logic        tdi_in,
    output logic             tdo_out,
    // Parallel side
    input  wire logic [31:0] cap_data_in,
    output logic             upd_pulse_out,
    output logic             rw_out,
    output logic [5:0]       addr_out,
    output logic [31:0]      data_out
);

    logic [SC_LEN-1:0] sr_reg;

    wire do_cap = select_in & capture_in;
    wire do_sh  = select_in & shift_in;
    wire do_upd = select_in & update_in;

    // Serial input enters at the read/write bit, leaves at bit 0
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sr_reg <= '0;
        end else if (do_cap) begin
            sr_reg[31:0] <= cap_data_in;
        end else if (do_sh) begin
            sr_reg <= {tdi_in, sr_reg[SC_LEN-1:1]};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            upd_pulse_out <= 1'b0;
            rw_out        <= 1'b0;
            addr_out      <= 6'h00;
            data_out      <= 32'h0000_0000;
            tdo_out       <= 1'b0;
        end else begin
            upd_pulse_out <= do_upd;
            rw_out        <= sr_reg[SC_RW_BIT];
            addr_out      <= sr_reg[SC_ADDR_HI:SC_ADDR_LO];
            data_out      <= sr_reg[31:0];
            tdo_out       <= do_sh ? sr_reg[1] : sr_reg[0];
        end
    end

    upd_one_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        upd_pulse_out |=> !upd_pulse_out || $past(do_upd))
        else $error("update pulse without update strobe");

endmodule

// >>> verilog/dbec_top.sv
`timescale 1ns/10ps
module dbec_top
    import dbec_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // Fetch side
    input  wire logic        pipe_adv_in,
    input  wire logic        fetch_valid_in,
    input  wire logic        fetch_abort_in,
    input  wire logic        int_break_in,
    input  wire logic        ext_instr_break_in,
    // Execute side
    input  wire logic        exec_swi_undef_in,
    input  wire logic        instr_done_in,
    input  wire logic        single_cycle_dp_in,
    input  wire logic        exc_entry_done_in,
    input  wire logic [31:0] pc_in,
    // Data side
    input  wire logic        data_access_in,
    input  wire logic        data_abort_in,
    input  wire logic        int_watch_in,
    input  wire logic        ext_data_watch_in,
    input  wire logic        sys_write_hit_in,
    input  wire logic        write_back_in,
    // Interrupts and debugger requests
    input  wire logic        normal_irq_n_in,
    input  wire logic        fast_irq_n_in,
    input  wire logic        ext_halt_request_in,
    input  wire logic        restart_in,
    // Scan chain strobes
    input  wire logic        sc_select_in,
    input  wire logic        sc_capture_in,
    input  wire logic        sc_shift_in,
    input  wire logic        sc_update_in,
    input  wire logic        sc_tdi_in,
    output logic             sc_tdo_out,
    // Core control
    output logic             halted_ack_out,
    output logic             irq_block_out,
    output logic             exec_suppress_out,
    output logic             debug_entry_out,
    output logic             watch_entry_out,
    output logic [31:0]      debug_pc_out,
    output logic             take_irq_out,
    output logic             take_pabort_out,
    output logic             take_dabort_out,
    output logic             take_swi_undef_out,
    // Cache write policy
    output logic             dirty_set_out,
    output logic             mem_write_out
);

    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    dbec_state_t state_reg;
    dbec_state_t state_next;
    logic        dec_valid_reg;
    logic        dec_bkpt_reg;
    logic        dec_pab_reg;
    logic        exe_bkpt_reg;
    logic        exe_pab_reg;
    logic        exe_fresh_reg;
    logic [31:0] idx_reg;
    logic [31:0] hold_reg;
    logic        rd_pend_reg;
    logic        rd_tag_reg;

    // Request decode
    wire brk_fetch = ext_instr_break_in | int_break_in;
    wire irq_pend  = ~normal_irq_n_in | ~fast_irq_n_in;
    wire watch_hit = data_access_in &
                     (ext_data_watch_in | int_watch_in);
    wire run       = (state_reg == ST_RUN);
    wire exe_now   = run & exe_fresh_reg;

    // Execute-stage priority: interrupt, prefetch abort, breakpoint
    wire bk_irq    = exe_now & exe_bkpt_reg & irq_pend;
    wire bk_pab    = exe_now & exe_pab_reg & ~irq_pend;
    wire bk_enter  = exe_now & exe_bkpt_reg & ~exe_pab_reg
                     & ~irq_pend;
    wire swi_exc   = exe_now & exec_swi_undef_in & ~exe_bkpt_reg
                     & ~exe_pab_reg & ~irq_pend;
    wire halt_req  = run & ext_halt_request_in & instr_done_in
                     & ~bk_enter;
    wire w_go      = run & watch_hit & ~bk_enter & ~halt_req;
    wire w_abort   = w_go & data_abort_in;
    wire w_irq     = w_go & ~data_abort_in & irq_pend;
    wire halt_enter = (state_next == ST_HALT) & (state_reg != ST_HALT);
    wire from_watch = halt_enter & ~run;
    wire flush     = bk_irq | halt_enter;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (bk_enter | halt_req) begin
                    state_next = ST_HALT;
                end else if (w_abort | w_irq) begin
                    state_next = ST_EXCSEQ;
                end else if (w_go) begin
                    state_next = ST_WATCH;
                end
            end
            ST_WATCH: begin
                if (instr_done_in) begin
                    state_next = single_cycle_dp_in ?
                                 ST_WDELAY : ST_HALT;
                end
            end
            ST_WDELAY: begin
                state_next = ST_HALT;
            end
            ST_EXCSEQ: begin
                if (exc_entry_done_in) begin
                    state_next = ST_HALT;
                end
            end
            ST_HALT: begin
                if (restart_in) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Break flags ride along with the instruction to Execute
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid_reg <= 1'b0;
            dec_bkpt_reg  <= 1'b0;
            dec_pab_reg   <= 1'b0;
            exe_bkpt_reg  <= 1'b0;
            exe_pab_reg   <= 1'b0;
            exe_fresh_reg <= 1'b0;
        end else if (flush) begin
            // Discarded instruction is refetched, so its flags go
            dec_valid_reg <= 1'b0;
            dec_bkpt_reg  <= 1'b0;
            dec_pab_reg   <= 1'b0;
            exe_bkpt_reg  <= 1'b0;
            exe_pab_reg   <= 1'b0;
            exe_fresh_reg <= 1'b0;
        end else if (pipe_adv_in) begin
            dec_valid_reg <= fetch_valid_in;
            dec_bkpt_reg  <= fetch_valid_in & brk_fetch;
            dec_pab_reg   <= fetch_valid_in & fetch_abort_in;
            exe_bkpt_reg  <= dec_bkpt_reg;
            exe_pab_reg   <= dec_pab_reg;
            exe_fresh_reg <= dec_valid_reg;
        end else begin
            exe_fresh_reg <= 1'b0;
        end
    end

    // Status word mask bits are left alone; blocking is a separate line
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            halted_ack_out     <= 1'b0;
            irq_block_out      <= 1'b0;
            exec_suppress_out  <= 1'b0;
            debug_entry_out    <= 1'b0;
            watch_entry_out    <= 1'b0;
            debug_pc_out       <= 32'h0000_0000;
            take_irq_out       <= 1'b0;
            take_pabort_out    <= 1'b0;
            take_dabort_out    <= 1'b0;
            take_swi_undef_out <= 1'b0;
            dirty_set_out      <= 1'b0;
            mem_write_out      <= 1'b0;
        end else begin
            halted_ack_out     <= (state_next == ST_HALT);
            irq_block_out      <= (state_next == ST_HALT);
            exec_suppress_out  <= bk_enter;
            debug_entry_out    <= halt_enter;
            watch_entry_out    <= from_watch;
            take_irq_out       <= bk_irq | w_irq;
            take_pabort_out    <= bk_pab;
            take_dabort_out    <= w_abort;
            take_swi_undef_out <= swi_exc;
            dirty_set_out      <= sys_write_hit_in & write_back_in;
            mem_write_out      <= sys_write_hit_in & ~write_back_in;
            if (from_watch) begin
                debug_pc_out <= pc_in + WATCH_PC_SKEW;
            end
        end
    end

    // Scan chain and cache arrays
    logic        sc_upd;
    logic        sc_rw;
    logic [5:0]  sc_addr;
    logic [31:0] sc_data;
    logic [31:0] ram_rdata;

    dbec_scan15 u_scan (
        .clk_in        (mclk_in),
        .rst_n_in      (rst_n),
        .select_in     (sc_select_in),
        .capture_in    (sc_capture_in),
        .shift_in      (sc_shift_in),
        .update_in     (sc_update_in),
        .tdi_in        (sc_tdi_in),
        .tdo_out       (sc_tdo_out),
        .cap_data_in   (hold_reg),
        .upd_pulse_out (sc_upd),
        .rw_out        (sc_rw),
        .addr_out      (sc_addr),
        .data_out      (sc_data)
    );

    wire        is_idx   = (sc_addr == SC_CACHE_INDEX);
    wire        is_arr   = (sc_addr[5:2] == SC_ARRAY_GROUP);
    wire [1:0]  arr_sel  = sc_addr[1:0];
    wire        idx_wr   = sc_upd & sc_rw & is_idx;
    wire        idx_rd   = sc_upd & ~sc_rw & is_idx;
    wire        ram_we   = sc_upd & sc_rw & is_arr;
    wire        ram_re   = sc_upd & ~sc_rw & is_arr;
    // Tags are one per line, so the word field is ignored for them
    wire [2:0]  ram_word = arr_sel[1] ? 3'h0 :
                           idx_reg[IDX_WORD_HI:IDX_WORD_LO];
    wire [RAM_AW-1:0] ram_addr = {arr_sel,
                                  idx_reg[IDX_SEG_HI:IDX_SEG_LO],
                                  idx_reg[IDX_N:IDX_LO],
                                  ram_word};
    // Same layout whatever the cache size
    wire [31:0] tag_fmt  = {ram_rdata[31:IDX_N+1],
                            idx_reg[IDX_N:IDX_LO],
                            5'h00};

    dbec_cache_ram u_ram (
        .clk_in    (mclk_in),
        .wr_en_in  (ram_we),
        .rd_en_in  (ram_re),
        .addr_in   (ram_addr),
        .wdata_in  (sc_data),
        .rdata_out (ram_rdata)
    );

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg     <= IDX_RESET;
            hold_reg    <= 32'h0000_0000;
            rd_pend_reg <= 1'b0;
            rd_tag_reg  <= 1'b0;
        end else begin
            rd_pend_reg <= ram_re;
            if (ram_re) begin
                rd_tag_reg <= arr_sel[1];
            end
            if (idx_wr) begin
                idx_reg <= sc_data & IDX_MASK;
            end
            if (idx_rd) begin
                hold_reg <= idx_reg;
            end else if (rd_pend_reg) begin
                hold_reg <= rd_tag_reg ? tag_fmt : ram_rdata;
            end else if (sc_upd & ~sc_rw) begin
                hold_reg <= 32'h0000_0000;
            end
        end
    end

    bkpt_or_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        pipe_adv_in && !flush && fetch_valid_in && !fetch_abort_in
        && (ext_instr_break_in || int_break_in)
        |=> dec_bkpt_reg)
        else $error("fetch break not latched");

    bkpt_entry_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        exe_now && exe_bkpt_reg && !exe_pab_reg && !irq_pend
        |=> exec_suppress_out && debug_entry_out && halted_ack_out)
        else $error("breakpoint did not suppress and enter");

    pabort_win_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        exe_now && exe_pab_reg && !irq_pend
        |=> take_pabort_out && !exec_suppress_out && !halted_ack_out)
        else $error("prefetch abort lost to breakpoint");

    irq_wins_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        exe_now && exe_bkpt_reg && irq_pend
        |=> take_irq_out && !halted_ack_out && !exe_bkpt_reg)
        else $error("interrupt lost to breakpoint");

    irq_block_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        halted_ack_out |-> irq_block_out)
        else $error("interrupts live while halted");

    dp_delay_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        state_reg == ST_WATCH && instr_done_in && single_cycle_dp_in
        |=> !halted_ack_out ##1 halted_ack_out && watch_entry_out)
        else $error("watch entry delay wrong");

    watch_pc_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        from_watch |=> debug_pc_out == $past(pc_in) + WATCH_PC_SKEW)
        else $error("watch entry PC skew wrong");

    abort_first_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        w_abort |=> take_dabort_out && !halted_ack_out)
        else $error("watch abort entered debug early");

    scan_no_mem_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        ram_we && !sys_write_hit_in |=> !mem_write_out)
        else $error("scan cache write reached memory");

    idx_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        idx_wr |=> idx_reg == ($past(sc_data) & IDX_MASK))
        else $error("index register write wrong");

endmodule

// >>> tb/dbec_tap_model.sv
`timescale 1ns/10ps
module dbec_tap_model (
    // Clock
    input  wire logic clk_in,
    // Scan strobes toward the chain
    output logic      sel_out,
    output logic      cap_out,
    output logic      shf_out,
    output logic      upd_out,
    output logic      tdi_out,
    input  wire logic tdo_in
);
    initial {sel_out, cap_out, shf_out, upd_out, tdi_out} = 5'h00;

    // One full frame in, then capture and shift back out
    task automatic xfer(input logic [38:0] w, output logic [31:0] r);
        for (int i = 0; i < 39; i++) begin
            @(posedge clk_in);
            {sel_out, shf_out} <= 2'h3;
            tdi_out <= w[i];
        end
        @(posedge clk_in);
        {shf_out, upd_out} <= 2'h1;
        @(posedge clk_in);
        upd_out <= 1'b0;
        // Line is not held once the frame is over
        tdi_out <= ~tdi_out;
        repeat (3) @(posedge clk_in);
        cap_out <= 1'b1;
        @(posedge clk_in);
        cap_out <= 1'b0;
        @(posedge clk_in);
        shf_out <= 1'b1;
        #1 r[0] = tdo_in;
        for (int j = 1; j < 32; j++) begin
            @(posedge clk_in);
            #1 r[j] = tdo_in;
        end
        @(posedge clk_in);
        {sel_out, shf_out} <= 2'h0;
    endtask
endmodule

// >>> tb/dbec_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module dbec_top_tb;
    import dbec_pkg::*;
    logic        mclk_in, rst_n_in, adv, fv, fab, ibk, ebk, swu, idone;
    logic        dp1, exd, dacc, dab, iwp, ewp, hit, wb, irq_n, fiq_n;
    logic        hreq, rst_go;
    logic [31:0] pc, rd, seed, wv, iv;
    wire         halted, blk, sup, ent, wen, tdo, sel, cap, shf, upd, tdi;
    wire         tpab, dirty, memw, tirq, tdab, tswi;
    wire  [31:0] dpc;
    logic [39:0] expq[$];
    int          n_errors, n_checks;

    dbec_top DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .pipe_adv_in(adv), .fetch_valid_in(fv), .fetch_abort_in(fab),
        .int_break_in(ibk), .ext_instr_break_in(ebk),
        .exec_swi_undef_in(swu), .instr_done_in(idone),
        .single_cycle_dp_in(dp1), .exc_entry_done_in(exd), .pc_in(pc),
        .data_access_in(dacc), .data_abort_in(dab), .int_watch_in(iwp),
        .ext_data_watch_in(ewp), .sys_write_hit_in(hit),
        .write_back_in(wb), .normal_irq_n_in(irq_n),
        .fast_irq_n_in(fiq_n), .ext_halt_request_in(hreq),
        .restart_in(rst_go), .sc_select_in(sel), .sc_capture_in(cap),
        .sc_shift_in(shf), .sc_update_in(upd), .sc_tdi_in(tdi),
        .sc_tdo_out(tdo), .halted_ack_out(halted), .irq_block_out(blk),
        .exec_suppress_out(sup), .debug_entry_out(ent),
        .watch_entry_out(wen), .debug_pc_out(dpc), .take_irq_out(tirq),
        .take_pabort_out(tpab), .take_dabort_out(tdab),
        .take_swi_undef_out(tswi), .dirty_set_out(dirty),
        .mem_write_out(memw));
    dbec_tap_model tap (.clk_in(mclk_in), .sel_out(sel), .cap_out(cap),
        .shf_out(shf), .upd_out(upd), .tdi_out(tdi), .tdo_in(tdo));

    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_halt(input logic v);
        int k;
        k = 0;
        while (halted !== v && k < 20) begin
            @(negedge mclk_in);
            k++;
        end
        if (k == 20) begin
            n_errors++;
            print_verdict();
        end
        `CHK(blk, v)
    endtask

    task automatic resume();
        @(posedge mclk_in) rst_go <= 1'b1;
        @(posedge mclk_in) rst_go <= 1'b0;
        wait_halt(1'b0);
    endtask

    // Any event pulse takes the oldest note
    always @(negedge mclk_in) begin
        if ((ent | tpab | dirty | memw | tirq | tdab | tswi) === 1'b1) begin
            if (expq.size() == 0) begin
                n_errors++;
                $display("wrong value t=%0t got %h exp none", $time, ent);
            end else
                `CHK({tirq, tdab, tswi, sup, wen, tpab, dirty, memw, wen ? dpc : 32'h0}, expq.pop_front())
        end
    end

    initial begin
        seed = 32'hb80887a4;
        {adv, fv, fab, ibk, ebk, swu, idone, dp1, exd, dacc} = 10'h000;
        {dab, iwp, ewp, hit, wb, hreq, rst_go} = 7'h00;
        {irq_n, fiq_n} = 2'h3;
        pc = 32'h0;
        rst_n_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        // Either comparator, fetch abort, irq, swi with and without break
        for (int i = 0; i < 7; i++) begin
            if (i == 2 || i == 3)
                expq.push_back(40'h04_0000_0000);
            else if (i == 4)
                expq.push_back(40'h80_0000_0000);
            else if (i == 6)
                expq.push_back(40'h20_0000_0000);
            else
                expq.push_back(40'h10_0000_0000);
            @(posedge mclk_in);
            {adv, fv, fab} <= {2'h3, i == 2 || i == 3};
            {ibk, ebk} <= {i[0], ~i[0] & (i != 6)};
            @(posedge mclk_in) {fv, fab, ibk, ebk} <= 4'h0;
            @(posedge mclk_in) adv <= 1'b0;
            swu <= (i >= 5);
            irq_n <= (i != 4);
            @(posedge mclk_in) {swu, irq_n} <= 2'h1;
            if (i >= 2 && i != 5)
                repeat (6) @(posedge mclk_in);
            else begin
                wait_halt(1'b1);
                resume();
            end
        end
        // Watch hit: plain follower, single-cycle follower, aborting access
        for (int i = 0; i < 3; i++) begin
            wv = rnd();
            if (i == 2)
                expq.push_back(40'h40_0000_0000);
            expq.push_back({8'h08, wv + WATCH_PC_SKEW});
            @(posedge mclk_in);
            pc <= wv;
            {dacc, iwp, ewp, dab} <= {1'b1, i[0], ~i[0], i[1]};
            @(posedge mclk_in) {dacc, iwp, ewp, dab} <= 4'h0;
            @(posedge mclk_in) {idone, dp1, exd} <= {i < 2, i[0], i[1]};
            @(posedge mclk_in) {idone, dp1, exd} <= 3'h0;
            @(negedge mclk_in) `CHK(halted, i != 1)
            wait_halt(1'b1);
            resume();
        end
        expq.push_back(37'h0);
        @(posedge mclk_in) {hreq, idone} <= 2'h3;
        @(posedge mclk_in) {hreq, idone} <= 2'h0;
        wait_halt(1'b1);
        resume();
        for (int i = 0; i < 2; i++) begin
            expq.push_back(i[0] ? 37'h02_0000_0000 : 37'h01_0000_0000);
            @(posedge mclk_in) {hit, wb} <= {1'b1, i[0]};
            @(posedge mclk_in) hit <= 1'b0;
            repeat (2) @(posedge mclk_in);
        end
        wv = rnd();
        iv = wv & IDX_MASK;
        tap.xfer({1'b1, SC_CACHE_INDEX, wv}, rd);
        tap.xfer({1'b0, SC_CACHE_INDEX, 32'h0}, rd);
        `CHK(rd, iv)
        wv = rnd();
        tap.xfer({1'b1, SC_ARRAY_GROUP, ARR_DDATA, wv}, rd);
        tap.xfer({1'b0, SC_ARRAY_GROUP, ARR_DDATA, 32'h0}, rd);
        `CHK(rd, wv)
        tap.xfer({1'b1, SC_ARRAY_GROUP, ARR_DTAG, wv}, rd);
        tap.xfer({1'b0, SC_ARRAY_GROUP, ARR_DTAG, 32'h0}, rd);
        `CHK(rd, {wv[31:10], iv[9:5], 5'h00})
        repeat (4) @(posedge mclk_in);
        `CHK(expq.size() == 0, 1'b1)
        print_verdict();
    end
endmodule
